// File: rtl/pmsr_pkg.sv
// constants for the power-management system and regulator control register bank
`default_nettype none

package pmsr_pkg;

	// ----------------------------------------------------------------
	// bus and clock
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CLK_KHZ = 250000;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SYS_MONITOR = 8'h00;
	localparam logic [7:0] OFS_SYS_MASTER = 8'h01;
	localparam logic [7:0] OFS_B1_PRIMARY = 8'h20;
	localparam logic [7:0] OFS_B1_SECONDARY = 8'h21;
	localparam logic [7:0] OFS_B1_CONTROL = 8'h22;
	localparam logic [7:0] OFS_B2_PRIMARY = 8'h30;
	localparam logic [7:0] OFS_B2_SECONDARY = 8'h31;
	localparam logic [7:0] OFS_B2_CONTROL = 8'h32;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] OFS_IRQ_MASK = 8'hF1;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_RESET_TIMEOUT = 7;
	localparam int unsigned BIT_MONITOR_MODE = 6;
	localparam int unsigned BIT_MONITOR_UNMASK = 5;
	localparam int unsigned BIT_SUPPLY_LOW = 4;
	localparam int unsigned THRESH_MSB = 3;
	localparam int unsigned BIT_MASTER_OFF = 5;
	localparam int unsigned SCRATCH_MSB = 3;
	localparam int unsigned VCODE_MSB = 5;
	localparam int unsigned BIT_ENABLE = 7;
	localparam int unsigned BIT_PHASE = 6;
	localparam int unsigned BIT_PWM_MODE = 5;
	localparam int unsigned DELAY_MSB = 4;
	localparam int unsigned DELAY_LSB = 2;
	localparam int unsigned BIT_FAULT_ENABLE = 1;
	localparam int unsigned BIT_POWER_GOOD = 0;
	localparam int unsigned IRQ_SUPPLY = 0;
	localparam int unsigned IRQ_B1_FAULT = 1;
	localparam int unsigned IRQ_B2_FAULT = 2;
	localparam int unsigned IRQ_W = 3;

	// ----------------------------------------------------------------
	// writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] WMASK_SYS_MONITOR = 8'hEF;
	localparam logic [7:0] WMASK_SYS_MASTER = 8'hFF;
	localparam logic [7:0] WMASK_VCODE = 8'h3F;
	localparam logic [7:0] WMASK_CONTROL = 8'hFE;
	localparam logic [7:0] RST_SYS_MONITOR = 8'h47;
	localparam logic [7:0] RST_SYS_MASTER = 8'h00;
	localparam logic [7:0] RST_B1_VCODE = 8'h39;
	localparam logic [7:0] RST_B2_VCODE = 8'h24;
	localparam logic [7:0] RST_CONTROL = 8'h80;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned RESET_TIMEOUT_SHORT_MS = 65;
	localparam int unsigned RESET_TIMEOUT_LONG_MS = 130;
	localparam int unsigned RESET_TIMEOUT_SHORT_CYC = RESET_TIMEOUT_SHORT_MS * CLK_KHZ;
	localparam int unsigned RESET_TIMEOUT_LONG_CYC = RESET_TIMEOUT_LONG_MS * CLK_KHZ;
	localparam int unsigned TIMEOUT_W = 26;

endpackage

`default_nettype wire

// File: rtl/pmsr_regs.sv
// control and status register bank for the system monitor and the first two buck regulators
// Functional notes
// R1 - reset timeout select bit one gives 65 ms, zero gives 130 ms
// R2 - monitor mode one raises interrupt on low supply; zero shuts down instead
// R3 - supply monitor interrupt masked after reset; unmask bit lets it through
// R4 - supply low status reads one while supply is below threshold
// R5 - four-bit threshold code in low bits of first system register
// R6 - master off switches off both bucks and linear regulator five
// R7 - master off self-clears on push button, and on valid charger on some variants
// R8 - four scratch bits, no function, cleared at undervoltage lockout
// R9 - primary code applies with select pin low, secondary with it high
// R10 - enable bit seven of each control register turns regulator on or off
// R11 - phase bit one switches 180 degrees out of phase, zero in phase
// R12 - mode bit one forces fixed PWM, zero allows light-load power saving
// R13 - three-bit field selects turn-on delay within power-up sequence
// R14 - fault enable bit one lets regulator faults interrupt, zero suppresses them
// R15 - power-good bit reads one while output is above its threshold
// R16 - all bits return to defaults at power removal or undervoltage lockout
// R17 - writes to read-only and reserved read-only bits are ignored
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module pmsr_regs
	import pmsr_pkg::*;
#(
	parameter int unsigned SHORT_TIMEOUT_CYCLES = RESET_TIMEOUT_SHORT_CYC,
	parameter int unsigned LONG_TIMEOUT_CYCLES  = RESET_TIMEOUT_LONG_CYC,
	parameter bit          CHARGER_CLEARS_OFF   = 1'b0
) (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	// register port
	input  wire logic [ADDR_W-1:0]     regAddr,
	input  wire logic [DATA_W-1:0]     regWriteData,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [DATA_W-1:0]     regReadData,
	// analog status inputs
	input  wire logic                  supplyBelowThreshold,
	input  wire logic                  supplyBelowLockout,
	input  wire logic                  pushButton_n,
	input  wire logic                  chargerValid,
	input  wire logic                  voltageSelectPin,
	input  wire logic                  buckOnePowerGood,
	input  wire logic                  buckTwoPowerGood,
	input  wire logic                  buckOneFault,
	input  wire logic                  buckTwoFault,
	// system controls
	output logic      [TIMEOUT_W-1:0]  resetTimeoutCycles,
	output logic      [THRESH_MSB:0]   supplyMonitorThreshold,
	output logic                       autoShutdown,
	output logic                       linearFiveOff,
	output logic                       interrupt,
	// buck regulator one
	output logic                       buckOneEnable,
	output logic      [VCODE_MSB:0]    buckOneVoltageCode,
	output logic                       buckOneAntiPhase,
	output logic                       buckOneForcedPwm,
	output logic      [2:0]            buckOneDelay,
	// buck regulator two
	output logic                       buckTwoEnable,
	output logic      [VCODE_MSB:0]    buckTwoVoltageCode,
	output logic                       buckTwoAntiPhase,
	output logic                       buckTwoForcedPwm,
	output logic      [2:0]            buckTwoDelay
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// keeps read-only bits of a stored register, takes writable ones from the bus
	function automatic logic [7:0] mergeWrite(input logic [7:0] oldVal, input logic [7:0] newVal,
		input logic [7:0] wmask);
		mergeWrite = (oldVal & ~wmask) | (newVal & wmask);
	endfunction

	function automatic logic [VCODE_MSB:0] pickCode(input logic sel, input logic [7:0] primary,
		input logic [7:0] secondary);
		pickCode = sel ? secondary[VCODE_MSB:0] : primary[VCODE_MSB:0];
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0]       sysMonitor;
	logic [7:0]       sysMaster;
	logic [7:0]       b1Primary;
	logic [7:0]       b1Secondary;
	logic [7:0]       b1Control;
	logic [7:0]       b2Primary;
	logic [7:0]       b2Secondary;
	logic [7:0]       b2Control;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	logic             supplyLowPrev;
	logic             b1FaultPrev;
	logic             b2FaultPrev;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic wrSysMonitor = regWrite && (regAddr == OFS_SYS_MONITOR);
	wire logic wrSysMaster  = regWrite && (regAddr == OFS_SYS_MASTER);
	wire logic wrB1Primary  = regWrite && (regAddr == OFS_B1_PRIMARY);
	wire logic wrB1Second   = regWrite && (regAddr == OFS_B1_SECONDARY);
	wire logic wrB1Control  = regWrite && (regAddr == OFS_B1_CONTROL);
	wire logic wrB2Primary  = regWrite && (regAddr == OFS_B2_PRIMARY);
	wire logic wrB2Second   = regWrite && (regAddr == OFS_B2_SECONDARY);
	wire logic wrB2Control  = regWrite && (regAddr == OFS_B2_CONTROL);
	wire logic wrIrqStatus  = regWrite && (regAddr == OFS_IRQ_STATUS);
	wire logic wrIrqMask    = regWrite && (regAddr == OFS_IRQ_MASK);

	// ----------------------------------------------------------------
	// events
	// ----------------------------------------------------------------
	wire logic monitorMode    = sysMonitor[BIT_MONITOR_MODE];
	wire logic monitorUnmask  = sysMonitor[BIT_MONITOR_UNMASK];
	// only a fresh drop below the threshold counts, not a level held low
	wire logic supplyDrop     = supplyBelowThreshold && !supplyLowPrev;
	wire logic supplyEvent    = supplyDrop && monitorMode && monitorUnmask; // R2 R3
	wire logic b1FaultEvent   = buckOneFault && !b1FaultPrev && b1Control[BIT_FAULT_ENABLE]; // R14
	wire logic b2FaultEvent   = buckTwoFault && !b2FaultPrev && b2Control[BIT_FAULT_ENABLE]; // R14
	wire logic [IRQ_W-1:0] irqEvents = {b2FaultEvent, b1FaultEvent, supplyEvent};
	wire logic [IRQ_W-1:0] irqClear  = wrIrqStatus ? regWriteData[IRQ_W-1:0] : {IRQ_W{1'b0}};
	// set wins over a write-one-to-clear in the same cycle
	wire logic [IRQ_W-1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvents;

	// ----------------------------------------------------------------
	// master off handling
	// ----------------------------------------------------------------
	wire logic offClear = !pushButton_n || (CHARGER_CLEARS_OFF && chargerValid); // R7
	wire logic [7:0] masterWritten = wrSysMaster ? regWriteData : sysMaster;
	// the hardware clear overrides a software set arriving in the same cycle
	wire logic [7:0] next_sysMaster = offClear ? (masterWritten & ~(8'h01 << BIT_MASTER_OFF)) // R7
		: masterWritten;
	wire logic masterOff = sysMaster[BIT_MASTER_OFF];

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire logic [7:0] statusMon = (sysMonitor & WMASK_SYS_MONITOR)
		| (8'(supplyBelowThreshold) << BIT_SUPPLY_LOW); // R4 R17
	wire logic [7:0] b1CtrlRd = (b1Control & WMASK_CONTROL) | 8'(buckOnePowerGood); // R15 R17
	wire logic [7:0] b2CtrlRd = (b2Control & WMASK_CONTROL) | 8'(buckTwoPowerGood); // R15 R17
	logic [7:0] next_readData;

	always_comb begin
		unique case (regAddr)
			OFS_SYS_MONITOR:  next_readData = statusMon;
			OFS_SYS_MASTER:   next_readData = sysMaster;
			OFS_B1_PRIMARY:   next_readData = b1Primary & WMASK_VCODE; // R17
			OFS_B1_SECONDARY: next_readData = b1Secondary & WMASK_VCODE;
			OFS_B1_CONTROL:   next_readData = b1CtrlRd;
			OFS_B2_PRIMARY:   next_readData = b2Primary & WMASK_VCODE;
			OFS_B2_SECONDARY: next_readData = b2Secondary & WMASK_VCODE;
			OFS_B2_CONTROL:   next_readData = b2CtrlRd;
			OFS_IRQ_STATUS:   next_readData = {5'h00, irqStatus};
			OFS_IRQ_MASK:     next_readData = {5'h00, irqMask};
			default:          next_readData = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// derived controls
	// ----------------------------------------------------------------
	wire logic [TIMEOUT_W-1:0] next_timeout = sysMonitor[BIT_RESET_TIMEOUT] // R1
		? TIMEOUT_W'(SHORT_TIMEOUT_CYCLES) : TIMEOUT_W'(LONG_TIMEOUT_CYCLES);
	// shut down only while the monitor is in shutdown mode and supply sits low
	wire logic next_shutdown = !monitorMode && supplyBelowThreshold; // R2
	wire logic next_b1Enable = b1Control[BIT_ENABLE] && !masterOff; // R6 R10
	wire logic next_b2Enable = b2Control[BIT_ENABLE] && !masterOff; // R6 R10
	wire logic [VCODE_MSB:0] next_b1Code = pickCode(voltageSelectPin, b1Primary, b1Secondary); // R9
	wire logic [VCODE_MSB:0] next_b2Code = pickCode(voltageSelectPin, b2Primary, b2Secondary); // R9
	// lockout wipes status and mask, so no pulse may escape in that cycle
	wire logic next_irq = !supplyBelowLockout && |(next_irqStatus & irqMask); // R16

	// ----------------------------------------------------------------
	// system registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sysMonitor <= RST_SYS_MONITOR; // R3
			sysMaster  <= RST_SYS_MASTER;
		end else if (supplyBelowLockout) begin
			sysMonitor <= RST_SYS_MONITOR; // R16
			sysMaster  <= RST_SYS_MASTER; // R8 R16
		end else begin
			if (wrSysMonitor)
				sysMonitor <= mergeWrite(sysMonitor, regWriteData, WMASK_SYS_MONITOR); // R5 R17
			sysMaster <= next_sysMaster; // R6 R8
		end
	end

	// ----------------------------------------------------------------
	// buck regulator registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			b1Primary   <= RST_B1_VCODE;
			b1Secondary <= RST_B1_VCODE;
			b1Control   <= RST_CONTROL;
			b2Primary   <= RST_B2_VCODE;
			b2Secondary <= RST_B2_VCODE;
			b2Control   <= RST_CONTROL;
		end else if (supplyBelowLockout) begin
			b1Primary   <= RST_B1_VCODE; // R16
			b1Secondary <= RST_B1_VCODE;
			b1Control   <= RST_CONTROL;
			b2Primary   <= RST_B2_VCODE;
			b2Secondary <= RST_B2_VCODE;
			b2Control   <= RST_CONTROL;
		end else begin
			if (wrB1Primary)
				b1Primary <= mergeWrite(b1Primary, regWriteData, WMASK_VCODE); // R17
			if (wrB1Second)
				b1Secondary <= mergeWrite(b1Secondary, regWriteData, WMASK_VCODE);
			if (wrB1Control)
				b1Control <= mergeWrite(b1Control, regWriteData, WMASK_CONTROL); // R10 R17
			if (wrB2Primary)
				b2Primary <= mergeWrite(b2Primary, regWriteData, WMASK_VCODE);
			if (wrB2Second)
				b2Secondary <= mergeWrite(b2Secondary, regWriteData, WMASK_VCODE);
			if (wrB2Control)
				b2Control <= mergeWrite(b2Control, regWriteData, WMASK_CONTROL); // R10 R17
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStatus     <= RST_IRQ;
			irqMask       <= RST_IRQ;
			supplyLowPrev <= 1'b0;
			b1FaultPrev   <= 1'b0;
			b2FaultPrev   <= 1'b0;
		end else begin
			irqStatus     <= supplyBelowLockout ? RST_IRQ : next_irqStatus;
			irqMask       <= supplyBelowLockout ? RST_IRQ
				: (wrIrqMask ? regWriteData[IRQ_W-1:0] : irqMask);
			supplyLowPrev <= supplyBelowThreshold;
			b1FaultPrev   <= buckOneFault;
			b2FaultPrev   <= buckTwoFault;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			regReadData            <= 8'h00;
			resetTimeoutCycles     <= TIMEOUT_W'(LONG_TIMEOUT_CYCLES);
			supplyMonitorThreshold <= RST_SYS_MONITOR[THRESH_MSB:0];
			autoShutdown           <= 1'b0;
			linearFiveOff          <= 1'b0;
			interrupt              <= 1'b0;
		end else begin
			regReadData            <= regRead ? next_readData : 8'h00;
			resetTimeoutCycles     <= next_timeout; // R1
			supplyMonitorThreshold <= sysMonitor[THRESH_MSB:0]; // R5
			autoShutdown           <= next_shutdown; // R2
			linearFiveOff          <= masterOff; // R6
			interrupt              <= next_irq;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			buckOneEnable      <= 1'b0;
			buckOneVoltageCode <= RST_B1_VCODE[VCODE_MSB:0];
			buckOneAntiPhase   <= 1'b0;
			buckOneForcedPwm   <= 1'b0;
			buckOneDelay       <= 3'h0;
			buckTwoEnable      <= 1'b0;
			buckTwoVoltageCode <= RST_B2_VCODE[VCODE_MSB:0];
			buckTwoAntiPhase   <= 1'b0;
			buckTwoForcedPwm   <= 1'b0;
			buckTwoDelay       <= 3'h0;
		end else begin
			buckOneEnable      <= next_b1Enable;
			buckOneVoltageCode <= next_b1Code;
			buckOneAntiPhase   <= b1Control[BIT_PHASE]; // R11
			buckOneForcedPwm   <= b1Control[BIT_PWM_MODE]; // R12
			buckOneDelay       <= b1Control[DELAY_MSB:DELAY_LSB]; // R13
			buckTwoEnable      <= next_b2Enable;
			buckTwoVoltageCode <= next_b2Code;
			buckTwoAntiPhase   <= b2Control[BIT_PHASE]; // R11
			buckTwoForcedPwm   <= b2Control[BIT_PWM_MODE]; // R12
			buckTwoDelay       <= b2Control[DELAY_MSB:DELAY_LSB]; // R13
		end
	end

endmodule

`default_nettype wire

// File: verification/pmsr_regs_asserts.sv
// concurrent checks on the ports of the power-management register bank
`timescale 1ns/1ns
`default_nettype none

module pmsr_regs_asserts
	import pmsr_pkg::*;
#(
	parameter int unsigned SHORT_TIMEOUT_CYCLES = 10,
	parameter int unsigned LONG_TIMEOUT_CYCLES  = 20
) (
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	// register port
	input wire logic [ADDR_W-1:0]    regAddr,
	input wire logic [DATA_W-1:0]    regWriteData,
	input wire logic                 regWrite,
	input wire logic                 regRead,
	input wire logic [DATA_W-1:0]    regReadData,
	// status inputs
	input wire logic                 supplyBelowThreshold,
	input wire logic                 supplyBelowLockout,
	input wire logic                 pushButton_n,
	input wire logic                 voltageSelectPin,
	// controls
	input wire logic [TIMEOUT_W-1:0] resetTimeoutCycles,
	input wire logic                 autoShutdown,
	input wire logic                 linearFiveOff,
	input wire logic                 interrupt,
	input wire logic                 buckOneEnable,
	input wire logic [VCODE_MSB:0]   buckOneVoltageCode,
	input wire logic                 buckOneAntiPhase,
	input wire logic                 buckOneForcedPwm,
	input wire logic [2:0]           buckOneDelay,
	input wire logic                 buckTwoEnable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// a write only counts when lockout is away at the write edge and the one after
	wire logic wrOk;
	assign wrOk = regWrite && !supplyBelowLockout;

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_tmo; wrOk && regAddr == OFS_SYS_MONITOR ##1 !supplyBelowLockout |=>
		resetTimeoutCycles == ($past(regWriteData, 2) >= 8'h80 ? SHORT_TIMEOUT_CYCLES : LONG_TIMEOUT_CYCLES); endproperty
	a_tmo: assert property (p_tmo) else $error("timeout value not set by select bit");
	property p_shut; autoShutdown |-> $past(supplyBelowThreshold); endproperty
	a_shut: assert property (p_shut) else $error("shutdown without low supply");
	property p_low; regRead && regAddr == OFS_SYS_MONITOR && supplyBelowThreshold == $past(supplyBelowThreshold)
		|=> regReadData[4] == $past(supplyBelowThreshold); endproperty
	a_low: assert property (p_low) else $error("supply status bit wrong");
	property p_off; linearFiveOff |-> !buckOneEnable && !buckTwoEnable; endproperty
	a_off: assert property (p_off) else $error("regulator on during master off");
	property p_pb; !pushButton_n |-> ##2 !linearFiveOff; endproperty
	a_pb: assert property (p_pb) else $error("master off kept after push button");
	property p_sel; wrOk && regAddr == OFS_B1_PRIMARY ##1 !supplyBelowLockout && !voltageSelectPin
		|=> buckOneVoltageCode == ($past(regWriteData, 2) & 8'h3F); endproperty
	a_sel: assert property (p_sel) else $error("primary code not applied");
	property p_ctl; wrOk && regAddr == OFS_B1_CONTROL ##1 !supplyBelowLockout |=>
		{buckOneEnable, buckOneAntiPhase, buckOneForcedPwm, buckOneDelay}
		== (($past(regWriteData, 2) >> 2) & {~linearFiveOff, 5'h1F}); endproperty
	a_ctl: assert property (p_ctl) else $error("control fields not applied");
	property p_undervoltage_lockout; supplyBelowLockout |-> ##2 !linearFiveOff && buckOneEnable
		&& resetTimeoutCycles == LONG_TIMEOUT_CYCLES; endproperty
	a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("defaults not restored in lockout");
	property p_irqoff; supplyBelowLockout |=> !interrupt; endproperty
	a_irqoff: assert property (p_irqoff) else $error("interrupt raised during lockout");
	property p_rsv; regRead && (regAddr == OFS_B1_PRIMARY || regAddr == OFS_B1_SECONDARY)
		|=> regReadData[7:6] == 2'b00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code bits not zero");
endmodule

bind pmsr_regs pmsr_regs_asserts #(.SHORT_TIMEOUT_CYCLES(SHORT_TIMEOUT_CYCLES),
	.LONG_TIMEOUT_CYCLES(LONG_TIMEOUT_CYCLES)) chk_u (
	.ref_clk, .reset_n, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
	.supplyBelowThreshold, .supplyBelowLockout, .pushButton_n, .voltageSelectPin,
	.resetTimeoutCycles, .autoShutdown, .linearFiveOff, .interrupt, .buckOneEnable, .buckOneVoltageCode,
	.buckOneAntiPhase, .buckOneForcedPwm, .buckOneDelay, .buckTwoEnable);
`default_nettype wire

// File: verification/pmsr_regs_tb.sv
// self-checking bench for the power-management register bank
`timescale 1ns/1ns
`default_nettype none

module pmsr_regs_tb
	import pmsr_pkg::*;
;
	// short timeouts keep the output values readable
	localparam int unsigned SHORT_CYC = 10;
	localparam int unsigned LONG_CYC  = 20;
	localparam logic [15:0] RST_TAB [10] = '{16'h0047, 16'h0100, 16'h2039, 16'h2139, 16'h3024,
		16'h3124, 16'h2281, 16'h3280, 16'hF000, 16'hF100};

	logic                 ref_clk, reset_n, regWrite, regRead, supplyBelowThreshold, supplyBelowLockout;
	logic                 pushButton_n, chargerValid, voltageSelectPin, buckOnePowerGood, buckTwoPowerGood;
	logic                 buckOneFault, buckTwoFault, autoShutdown, linearFiveOff, interrupt;
	logic                 buckOneEnable, buckOneAntiPhase, buckOneForcedPwm, buckTwoEnable;
	logic                 buckTwoAntiPhase, buckTwoForcedPwm;
	logic [7:0]           regAddr, regWriteData, regReadData;
	logic [TIMEOUT_W-1:0] resetTimeoutCycles;
	logic [THRESH_MSB:0]  supplyMonitorThreshold;
	logic [VCODE_MSB:0]   buckOneVoltageCode, buckTwoVoltageCode;
	logic [2:0]           buckOneDelay, buckTwoDelay;
	int                   errorCnt, samplesChecked;

	pmsr_regs #(.SHORT_TIMEOUT_CYCLES(SHORT_CYC), .LONG_TIMEOUT_CYCLES(LONG_CYC)) dut_u (
		.ref_clk, .reset_n, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
		.supplyBelowThreshold, .supplyBelowLockout, .pushButton_n, .chargerValid, .voltageSelectPin,
		.buckOnePowerGood, .buckTwoPowerGood, .buckOneFault, .buckTwoFault, .resetTimeoutCycles,
		.supplyMonitorThreshold, .autoShutdown, .linearFiveOff, .interrupt, .buckOneEnable,
		.buckOneVoltageCode, .buckOneAntiPhase, .buckOneForcedPwm, .buckOneDelay, .buckTwoEnable,
		.buckTwoVoltageCode, .buckTwoAntiPhase, .buckTwoForcedPwm, .buckTwoDelay);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite     <= 1'b1;
		regAddr      <= a;
		regWriteData <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 chk($sformatf("read %0h", a), {24'h0, e}, {24'h0, regReadData});
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	task automatic endOfTest();
		$display("checks %0d errors %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		errorCnt++;
		endOfTest();
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, regWrite, regRead, supplyBelowThreshold, supplyBelowLockout, chargerValid} = '0;
		{voltageSelectPin, buckTwoPowerGood, buckOneFault, buckTwoFault, regAddr, regWriteData} = '0;
		{pushButton_n, buckOnePowerGood} = 2'b11;
		errorCnt = 0;
		samplesChecked = 0;
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		foreach (RST_TAB[i]) rd(RST_TAB[i][15:8], RST_TAB[i][7:0]);
		chk("timeout", LONG_CYC, resetTimeoutCycles);
		wr(OFS_SYS_MONITOR, 8'h9A);
		settle();
		chk("timeout", SHORT_CYC, resetTimeoutCycles);
		chk("threshold", 32'hA, supplyMonitorThreshold);
		rd(OFS_SYS_MONITOR, 8'h8A);
		wr(OFS_SYS_MONITOR, 8'h05);
		rd(8'h40, 8'h00);
		chk("timeout", LONG_CYC, resetTimeoutCycles);
		wr(OFS_B1_PRIMARY, 8'hD5);
		wr(OFS_B1_SECONDARY, 8'h2A);
		wr(OFS_B2_PRIMARY, 8'h11);
		wr(OFS_B2_SECONDARY, 8'h3F);
		settle();
		chk("code one", 32'h15, buckOneVoltageCode);
		chk("code two", 32'h11, buckTwoVoltageCode);
		rd(OFS_B1_PRIMARY, 8'h15);
		@(posedge ref_clk);
		voltageSelectPin <= 1'b1;
		settle();
		chk("code one", 32'h2A, buckOneVoltageCode);
		chk("code two", 32'h3F, buckTwoVoltageCode);
		wr(OFS_B1_CONTROL, 8'h76);
		wr(OFS_B2_CONTROL, 8'hA9);
		settle();
		chk("ctl one", 32'h1D, {buckOneEnable, buckOneAntiPhase, buckOneForcedPwm, buckOneDelay});
		chk("ctl two", 32'h2A, {buckTwoEnable, buckTwoAntiPhase, buckTwoForcedPwm, buckTwoDelay});
		rd(OFS_B1_CONTROL, 8'h77);
		rd(OFS_B2_CONTROL, 8'hA8);
		buckOnePowerGood <= 1'b0;
		wr(OFS_B1_CONTROL, 8'h80);
		rd(OFS_B1_CONTROL, 8'h80);
		wr(OFS_SYS_MASTER, 8'h2A);
		chargerValid <= 1'b1;
		settle();
		chk("ldo off", 32'h1, linearFiveOff);
		chk("enables", 32'h0, {buckOneEnable, buckTwoEnable});
		chargerValid <= 1'b0;
		pushButton_n <= 1'b0;
		@(posedge ref_clk);
		pushButton_n <= 1'b1;
		settle();
		chk("ldo off", 32'h0, linearFiveOff);
		chk("enables", 32'h3, {buckOneEnable, buckTwoEnable});
		rd(OFS_SYS_MASTER, 8'h0A);
		supplyBelowLockout <= 1'b1;
		wr(OFS_SYS_MONITOR, 8'h80);
		supplyBelowLockout <= 1'b0;
		rd(OFS_SYS_MASTER, 8'h00);
		rd(OFS_SYS_MONITOR, 8'h47);
		rd(OFS_B2_PRIMARY, 8'h24);
		// supply event while still masked
		wr(OFS_IRQ_MASK, 8'h07);
		wr(OFS_B1_CONTROL, 8'h82);
		supplyBelowThreshold <= 1'b1;
		settle();
		chk("irq", 32'h0, interrupt);
		chk("shutdown", 32'h0, autoShutdown);
		rd(OFS_IRQ_STATUS, 8'h00);
		rd(OFS_SYS_MONITOR, 8'h57);
		supplyBelowThreshold <= 1'b0;
		wr(OFS_SYS_MONITOR, 8'h67);
		supplyBelowThreshold <= 1'b1;
		settle();
		chk("irq", 32'h1, interrupt);
		rd(OFS_IRQ_STATUS, 8'h01);
		wr(OFS_IRQ_STATUS, 8'h01);
		settle();
		chk("irq", 32'h0, interrupt);
		wr(OFS_SYS_MONITOR, 8'h07);
		settle();
		chk("shutdown", 32'h1, autoShutdown);
		supplyBelowThreshold <= 1'b0;
		settle();
		chk("shutdown", 32'h0, autoShutdown);
		rd(OFS_SYS_MONITOR, 8'h07);
		buckOneFault <= 1'b1;
		buckTwoFault <= 1'b1;
		settle();
		chk("irq", 32'h1, interrupt);
		rd(OFS_IRQ_STATUS, 8'h02);
		wr(OFS_IRQ_MASK, 8'h00);
		settle();
		chk("irq", 32'h0, interrupt);
		endOfTest();
	end
endmodule
`default_nettype wire
